//--- awd_pkg.sv
package awd_pkg;

    // =========================================================================
    // Register bus geometry.
    // =========================================================================
    localparam int unsigned AWD_ADDR_W = 4;
    localparam int unsigned AWD_DATA_W = 8;

    // =========================================================================
    // Register offsets.
    // =========================================================================
    localparam logic [3:0] AWD_OFS_CONTROL    = 4'h0;
    localparam logic [3:0] AWD_OFS_RESULT_HI  = 4'h1;
    localparam logic [3:0] AWD_OFS_RESULT_LO  = 4'h2;
    localparam logic [3:0] AWD_OFS_UPPER_HI   = 4'h3;
    localparam logic [3:0] AWD_OFS_UPPER_LO   = 4'h4;
    localparam logic [3:0] AWD_OFS_LOWER_HI   = 4'h5;
    localparam logic [3:0] AWD_OFS_LOWER_LO   = 4'h6;
    localparam logic [3:0] AWD_OFS_IRQ_STATUS = 4'h7;
    localparam logic [3:0] AWD_OFS_IRQ_CLEAR  = 4'h8;
    localparam logic [3:0] AWD_OFS_IRQ_ENABLE = 4'h9;

    // =========================================================================
    // Field positions.
    // =========================================================================
    localparam int unsigned AWD_CTRL_LJUST_BIT = 0;
    localparam int unsigned AWD_CTRL_WFLAG_BIT = 1;
    localparam int unsigned AWD_EVT_WINDOW_BIT = 0;
    localparam int unsigned AWD_EVT_CONV_BIT   = 1;
    localparam int unsigned AWD_EVT_W          = 2;

    // =========================================================================
    // Reset values.
    // =========================================================================
    localparam logic [7:0] AWD_RST_LIMIT  = 8'h00;
    localparam logic [7:0] AWD_RST_RDATA  = 8'h00;
    localparam logic [1:0] AWD_RST_EVT    = 2'h0;
    localparam logic [7:0] AWD_UNMAPPED   = 8'h00;

    // =========================================================================
    // Converter word.
    // =========================================================================
    localparam int unsigned AWD_RES_BITS  = 10;
    localparam int unsigned AWD_WORD_W    = 16;

endpackage : awd_pkg

//--- awd_window_detector.sv
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
// Operation
// - Compare every new result automatically against limits.
// - Out-of-bound match sets flag, may interrupt.
// - Software may poll the flag any time.
// - Limit order selects inside or outside matching.
// - Left justify: result high, six low zeros.
module awd_window_detector
#(
    parameter int unsigned RES_BITS = awd_pkg::AWD_RES_BITS
) (
    // Clock and reset.
    input  wire logic                            sys_clk,
    input  wire logic                            reset,
    // Converter core results, same clock.
    input  wire logic                            conv_valid,
    input  wire logic [RES_BITS-1:0]             conv_data,
    // Register port.
    input  wire logic [awd_pkg::AWD_ADDR_W-1:0]  reg_addr,
    input  wire logic [awd_pkg::AWD_DATA_W-1:0]  reg_wdata,
    input  wire logic                            reg_wr,
    input  wire logic                            reg_rd,
    output logic      [awd_pkg::AWD_DATA_W-1:0]  reg_rdata,
    // Status and interrupt.
    output logic                                 window_match_flag,
    output logic                                 irq
);
    import awd_pkg::*;

    // =========================================================================
    // Register map.
    // =========================================================================
    // Index  Access  Contents
    //   0    RW      Bit 0 left_justify_select, bit 1 window_match_flag; writing
    //                0 to bit 1 clears the flag and writing 1 leaves it alone.
    //   1    RO      result_high_byte of the result word as formatted now.
    //   2    RO      result_low_byte of the result word as formatted now.
    //   3    RW      upper_limit_high_byte, the greater-than limit.
    //   4    RW      upper_limit_low_byte.
    //   5    RW      lower_limit_high_byte, the less-than limit.
    //   6    RW      lower_limit_low_byte.
    //   7    RO      Event status: bit 0 window match, bit 1 conversion done.
    //   8    WO      Event clear: a one clears the status bit beside it.
    //   9    RW      Event enable, laid out like the status register.
    // Unmapped indices read as zero and ignore writes.
    // A strobe is taken at the rising edge where it is high; a write takes
    // effect at that edge and read data stand for the next cycle only.
    // A result is taken with conv_valid; the flag and the status bits show
    // in the next cycle and irq one cycle after that.

    // =========================================================================
    // Parameter check.
    // =========================================================================
    if (RES_BITS < 1 || RES_BITS > AWD_WORD_W) begin : g_bad_res
        $error("RES_BITS must lie between 1 and 16");
    end

    if (AWD_EVT_W < 1 || AWD_EVT_W > AWD_DATA_W) begin : g_bad_evt
        $error("event bits must fit in one register byte");
    end

    if (AWD_CTRL_LJUST_BIT >= AWD_DATA_W || AWD_CTRL_WFLAG_BIT >= AWD_DATA_W) begin : g_bad_ctrl
        $error("control bits must fit in one register byte");
    end

    localparam int unsigned PAD_W = AWD_WORD_W - RES_BITS;

    // =========================================================================
    // State.
    // =========================================================================
    typedef struct packed {
        logic                  ljust;
        logic                  wflag;
        logic [RES_BITS-1:0]   result;
        logic [7:0]            upper_hi;
        logic [7:0]            upper_lo;
        logic [7:0]            lower_hi;
        logic [7:0]            lower_lo;
        logic [AWD_EVT_W-1:0]  evt_sts;
        logic [AWD_EVT_W-1:0]  evt_en;
        logic [7:0]            rdata;
        logic                  irq;
    } awd_state_t;

    awd_state_t state_ff;
    awd_state_t nxt_state;

    // =========================================================================
    // Data word formatting.
    // =========================================================================
    // The stored result is raw; justification is applied on the way out so
    // that changing the select reformats the last result without a new
    // conversion.
    function automatic logic [AWD_WORD_W-1:0] awd_format(
        input logic [RES_BITS-1:0] raw,
        input logic                left
    );
        logic [AWD_WORD_W-1:0] word;
        word = AWD_WORD_W'(raw);
        if (left) begin
            word = word << PAD_W;
        end
        return word;
    endfunction

    logic [AWD_WORD_W-1:0] new_word;
    logic [AWD_WORD_W-1:0] held_word;
    logic [AWD_WORD_W-1:0] upper_word;
    logic [AWD_WORD_W-1:0] lower_word;
    logic                  inside_mode;
    logic                  match;

    always_comb begin
        new_word   = awd_format(conv_data, state_ff.ljust);
        held_word  = awd_format(state_ff.result, state_ff.ljust);
        upper_word = {state_ff.upper_hi, state_ff.upper_lo};
        lower_word = {state_ff.lower_hi, state_ff.lower_lo};
        // Limits are compared against the word as software sees it, so they
        // must be written in the same justification as the results.
        inside_mode = (upper_word < lower_word);
        // A result equal to either limit never matches: both bounds are strict.
        if (inside_mode) begin
            match = (new_word > upper_word) && (new_word < lower_word);
        end else begin
            match = (new_word > upper_word) || (new_word < lower_word);
        end
    end

    // =========================================================================
    // Write decode and events.
    // =========================================================================
    // Every write strobe is decoded once here so that the state update below reads
    // plain enables; a write to a read-only or unmapped index decodes to none.
    logic                  wr_control;
    logic                  wr_upper_hi;
    logic                  wr_upper_lo;
    logic                  wr_lower_hi;
    logic                  wr_lower_lo;
    logic                  wr_evt_clear;
    logic                  wr_evt_enable;
    logic                  win_hit;
    logic                  wflag_clr;
    logic [AWD_EVT_W-1:0]  evt_set;
    logic [AWD_EVT_W-1:0]  evt_clr;
    logic [AWD_EVT_W-1:0]  evt_next;
    logic [AWD_DATA_W-1:0] ctrl_view;
    logic [AWD_DATA_W-1:0] sts_view;
    logic [AWD_DATA_W-1:0] en_view;

    always_comb begin
        wr_control    = 1'b0;
        wr_upper_hi   = 1'b0;
        wr_upper_lo   = 1'b0;
        wr_lower_hi   = 1'b0;
        wr_lower_lo   = 1'b0;
        wr_evt_clear  = 1'b0;
        wr_evt_enable = 1'b0;
        if (reg_wr) begin
            if (reg_addr == AWD_OFS_CONTROL) begin
                wr_control = 1'b1;
            end else if (reg_addr == AWD_OFS_UPPER_HI) begin
                wr_upper_hi = 1'b1;
            end else if (reg_addr == AWD_OFS_UPPER_LO) begin
                wr_upper_lo = 1'b1;
            end else if (reg_addr == AWD_OFS_LOWER_HI) begin
                wr_lower_hi = 1'b1;
            end else if (reg_addr == AWD_OFS_LOWER_LO) begin
                wr_lower_lo = 1'b1;
            end else if (reg_addr == AWD_OFS_IRQ_CLEAR) begin
                wr_evt_clear = 1'b1;
            end else if (reg_addr == AWD_OFS_IRQ_ENABLE) begin
                wr_evt_enable = 1'b1;
            end
        end
    end

    always_comb begin
        win_hit   = conv_valid && match;
        wflag_clr = wr_control && !reg_wdata[AWD_CTRL_WFLAG_BIT];
        evt_set   = '0;
        evt_set[AWD_EVT_WINDOW_BIT] = win_hit;
        evt_set[AWD_EVT_CONV_BIT]   = conv_valid;
        evt_clr   = '0;
        if (wr_evt_clear) begin
            evt_clr = reg_wdata[AWD_EVT_W-1:0];
        end
    end

    // Each status bit is its own sticky cell. An event in the same cycle as
    // its clear wins, so a badly timed clear can never swallow an event.
    for (genvar gi = 0; gi < AWD_EVT_W; gi++) begin : g_evt
        assign evt_next[gi] = evt_set[gi] | (state_ff.evt_sts[gi] & ~evt_clr[gi]);
    end

    // Readable views of the packed control and event registers.
    always_comb begin
        ctrl_view = AWD_RST_RDATA;
        ctrl_view[AWD_CTRL_LJUST_BIT] = state_ff.ljust;
        ctrl_view[AWD_CTRL_WFLAG_BIT] = state_ff.wflag;
        sts_view  = AWD_DATA_W'(state_ff.evt_sts);
        en_view   = AWD_DATA_W'(state_ff.evt_en);
    end

    // =========================================================================
    // Next state.
    // =========================================================================
    always_comb begin
        nxt_state = state_ff;

        if (conv_valid) begin
            nxt_state.result = conv_data;
        end

        // Register writes.
        if (wr_control) begin
            nxt_state.ljust = reg_wdata[AWD_CTRL_LJUST_BIT];
        end
        if (wr_upper_hi) begin
            nxt_state.upper_hi = reg_wdata;
        end
        if (wr_upper_lo) begin
            nxt_state.upper_lo = reg_wdata;
        end
        if (wr_lower_hi) begin
            nxt_state.lower_hi = reg_wdata;
        end
        if (wr_lower_lo) begin
            nxt_state.lower_lo = reg_wdata;
        end
        if (wr_evt_enable) begin
            nxt_state.evt_en = reg_wdata[AWD_EVT_W-1:0];
        end

        // A match in the same cycle as the software clear keeps the flag set.
        nxt_state.wflag   = win_hit | (state_ff.wflag & ~wflag_clr);
        nxt_state.evt_sts = evt_next;

        // Register reads: data stand only in the cycle after the strobe.
        // Between reads the port shows zero, never the last value read.
        nxt_state.rdata = AWD_RST_RDATA;
        if (reg_rd) begin
            if (reg_addr == AWD_OFS_CONTROL) begin
                nxt_state.rdata = ctrl_view;
            end else if (reg_addr == AWD_OFS_RESULT_HI) begin
                nxt_state.rdata = held_word[15:8];
            end else if (reg_addr == AWD_OFS_RESULT_LO) begin
                nxt_state.rdata = held_word[7:0];
            end else if (reg_addr == AWD_OFS_UPPER_HI) begin
                nxt_state.rdata = state_ff.upper_hi;
            end else if (reg_addr == AWD_OFS_UPPER_LO) begin
                nxt_state.rdata = state_ff.upper_lo;
            end else if (reg_addr == AWD_OFS_LOWER_HI) begin
                nxt_state.rdata = state_ff.lower_hi;
            end else if (reg_addr == AWD_OFS_LOWER_LO) begin
                nxt_state.rdata = state_ff.lower_lo;
            end else if (reg_addr == AWD_OFS_IRQ_STATUS) begin
                nxt_state.rdata = sts_view;
            end else if (reg_addr == AWD_OFS_IRQ_ENABLE) begin
                nxt_state.rdata = en_view;
            end else begin
                nxt_state.rdata = AWD_UNMAPPED;
            end
        end

        // The interrupt follows the registered status, one cycle behind it.
        // That cycle of latency buys an interrupt pin straight from a flop,
        // with no path from the register strobes.
        nxt_state.irq = |(state_ff.evt_sts & state_ff.evt_en);
    end

    // =========================================================================
    // Registers.
    // =========================================================================
    // Reset clears every field, so both limits start at zero: the detector is
    // then in outside mode and any non-zero result matches. Software should
    // load the limits before it enables the window interrupt.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_ff.ljust    <= 1'b0;
            state_ff.wflag    <= 1'b0;
            state_ff.result   <= '0;
            state_ff.upper_hi <= AWD_RST_LIMIT;
            state_ff.upper_lo <= AWD_RST_LIMIT;
            state_ff.lower_hi <= AWD_RST_LIMIT;
            state_ff.lower_lo <= AWD_RST_LIMIT;
            state_ff.evt_sts  <= AWD_RST_EVT;
            state_ff.evt_en   <= AWD_RST_EVT;
            state_ff.rdata    <= AWD_RST_RDATA;
            state_ff.irq      <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // =========================================================================
    // Outputs.
    // =========================================================================
    // All three outputs are plain register bits, so nothing downstream sees a
    // combinational path from the strobes or the converter result.
    always_comb begin
        reg_rdata         = state_ff.rdata;
        window_match_flag = state_ff.wflag;
        irq               = state_ff.irq;
    end

endmodule // awd_window_detector

//--- awd_window_detector_props.sv
`timescale 1ns/1ps
// ====================================================
// Port checker for the window detector.
module awd_window_detector_props
    import awd_pkg::*;
#(
    parameter int unsigned RES_BITS = 10
) (
    // Clock and reset.
    input wire logic                sys_clk,
    input wire logic                reset,
    // Converter and register port.
    input wire logic                conv_valid,
    input wire logic [RES_BITS-1:0] conv_data,
    input wire logic [3:0]          reg_addr,
    input wire logic [7:0]          reg_wdata,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [7:0]          reg_rdata,
    // Status.
    input wire logic                window_match_flag,
    input wire logic                irq
);
    logic [15:0] up_ff, lo_ff, word;
    logic        lj_ff, hit, clr;
    // Shadow limits let every result be judged on its own, not only those the bench picks.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            up_ff <= 16'h0000;
            lo_ff <= 16'h0000;
            lj_ff <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == AWD_OFS_CONTROL) lj_ff <= reg_wdata[0];
            if (reg_addr == AWD_OFS_UPPER_HI) up_ff[15:8] <= reg_wdata;
            if (reg_addr == AWD_OFS_UPPER_LO) up_ff[7:0] <= reg_wdata;
            if (reg_addr == AWD_OFS_LOWER_HI) lo_ff[15:8] <= reg_wdata;
            if (reg_addr == AWD_OFS_LOWER_LO) lo_ff[7:0] <= reg_wdata;
        end
    end
    assign word = lj_ff ? 16'({conv_data, 6'h00}) : 16'(conv_data);
    assign hit = (up_ff < lo_ff) ? (word > up_ff && word < lo_ff) : (word > up_ff || word < lo_ff);
    assign clr = reg_wr && reg_addr == AWD_OFS_CONTROL && !reg_wdata[1];
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence ctrl_read_s; reg_rd && reg_addr == AWD_OFS_CONTROL; endsequence
    sequence hit_taken_s; conv_valid && hit; endsequence
    sequence flag_clear_s; clr && !(conv_valid && hit); endsequence
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read cycle");
    match_sets_flag_a: assert property (hit_taken_s |=> window_match_flag)
        else $error("matching result did not set flag");
    flag_cause_a: assert property ($rose(window_match_flag) |-> $past(conv_valid && hit))
        else $error("flag rose without a matching result");
    flag_hold_a: assert property (window_match_flag && !clr |=> window_match_flag)
        else $error("flag dropped without a clear");
    flag_clear_a: assert property (flag_clear_s |=> !window_match_flag)
        else $error("flag survived a clear");
    flag_poll_a: assert property (ctrl_read_s |=> reg_rdata == {6'h00, $past(window_match_flag), $past(lj_ff)})
        else $error("control read does not show flag");
    ljust_low_a: assert property (reg_rd && reg_addr == AWD_OFS_RESULT_LO && lj_ff |=> reg_rdata[5:0] == 6'h00)
        else $error("left justified low bits not zero");
    irq_off_a: assert property ($past(reg_wr && reg_addr == AWD_OFS_IRQ_ENABLE && reg_wdata == 8'h00, 2) |-> !irq)
        else $error("interrupt high with enables off");
    irq_cause_a: assert property ($rose(irq) |-> $past(conv_valid, 2) || $past(reg_wr, 2))
        else $error("interrupt rose without cause");
endmodule // awd_window_detector_props

//--- awd_window_detector_tb_top.sv
`timescale 1ns/1ps
// ====================================================
// Bench for the window detector.
module awd_window_detector_tb_top;
    import awd_pkg::*;
    logic        sys_clk, reset, conv_valid, reg_wr, reg_rd, window_match_flag, irq, lj, h;
    logic [9:0]  conv_data, r;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, d;
    logic [15:0] up, lo, w;
    logic [31:0] seed = 32'd20;
    logic [31:0] x;
    int          failures, n_tests;
    awd_window_detector #(.RES_BITS(10)) uut (.*);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic hitf(input logic [15:0] v);
        return (up < lo) ? (v > up && v < lo) : (v > up || v < lo);
    endfunction
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic cnv(input logic [9:0] v);
        @(posedge sys_clk);
        conv_data <= v;
        conv_valid <= 1'b1;
        @(posedge sys_clk);
        conv_valid <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // A hang shows up as a spent budget rather than a silent stall.
    initial begin
        repeat (30000) @(posedge sys_clk);
        failures++;
        close_out();
    end
    initial begin
        {reset, conv_valid, reg_wr, reg_rd} = 4'hf;
        {conv_data, reg_addr, reg_wdata} = 22'h0;
        {conv_valid, reg_wr, reg_rd} = 3'h0;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        for (int a = 0; a < 16; a++) begin
            rd(a[3:0]);
            chk("reset_read", 16'h0000, {8'h00, d});
        end
        wr(AWD_OFS_IRQ_ENABLE, 8'h01);
        for (int i = 0; i < 40; i++) begin
            x = rnd();
            {up, lo} = x;
            x = rnd();
            {lj, r} = x[10:0];
            // Corners: a result equal to a limit must never match; one just below the lower limit in outside mode must.
            if (i == 0) {up, lo, lj, r} = {16'h0100, 16'h0200, 1'b0, 10'h100};
            if (i == 1) {up, lo, lj, r} = {16'hffc0, 16'h0000, 1'b1, 10'h3ff};
            if (i == 2) {up, lo, lj, r} = {16'h0200, 16'h0100, 1'b0, 10'h0ff};
            w = lj ? {r, 6'h00} : {6'h00, r};
            h = hitf(w);
            wr(AWD_OFS_CONTROL, {7'h00, lj});
            wr(AWD_OFS_IRQ_CLEAR, 8'h03);
            wr(AWD_OFS_UPPER_HI, up[15:8]);
            wr(AWD_OFS_UPPER_LO, up[7:0]);
            wr(AWD_OFS_LOWER_HI, lo[15:8]);
            wr(AWD_OFS_LOWER_LO, lo[7:0]);
            cnv(r);
            rd(AWD_OFS_CONTROL);
            chk("flag", {14'h0, h, lj}, {8'h00, d});
            chk("irq", {15'h0, h}, {15'h0, irq});
            rd(AWD_OFS_RESULT_HI);
            chk("res_hi", {8'h00, w[15:8]}, {8'h00, d});
            rd(AWD_OFS_RESULT_LO);
            chk("res_lo", {8'h00, w[7:0]}, {8'h00, d});
            wr(AWD_OFS_UPPER_HI, 8'hff);
            wr(AWD_OFS_UPPER_LO, 8'hff);
            wr(AWD_OFS_LOWER_HI, 8'h00);
            wr(AWD_OFS_LOWER_LO, 8'h00);
            cnv(r);
            rd(AWD_OFS_IRQ_STATUS);
            chk("sticky", {14'h0, 1'b1, h}, {8'h00, d});
            chk("flag_pin", {15'h0, h}, {15'h0, window_match_flag});
            wr(AWD_OFS_CONTROL, {6'h00, 1'b1, lj});
            rd(AWD_OFS_CONTROL);
            chk("keep", {14'h0, h, lj}, {8'h00, d});
            wr(AWD_OFS_CONTROL, {7'h00, lj});
            rd(AWD_OFS_CONTROL);
            chk("clear", {14'h0, 1'b0, lj}, {8'h00, d});
            chk("clear_pin", 16'h0000, {15'h0, window_match_flag});
            wr(AWD_OFS_IRQ_ENABLE, {7'h00, ~i[0]});
            rd(AWD_OFS_IRQ_ENABLE);
            chk("enable", {15'h0, ~i[0]}, {8'h00, d});
            chk("masked", {15'h0, h & ~i[0]}, {15'h0, irq});
            wr(AWD_OFS_IRQ_ENABLE, 8'h01);
        end
        close_out();
    end
endmodule // awd_window_detector_tb_top
bind awd_window_detector awd_window_detector_props #(.RES_BITS(RES_BITS)) chk_i (.*);
